// >>> ees_cmd_seq.sv
// EEPROM command sequencer: page buffer, page ops, erase, byte read, debug port
`timescale 1ns/1ns
module ees_cmd_seq
    import ees_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Software control
    input  wire logic [CMD_W-1:0]  cmd_field,
    input  wire logic              execute_command_bit,
    input  wire logic              config_change_protection,
    input  wire logic              addr_wr,
    input  wire logic [ADDR_W-1:0] addr_wdata,
    input  wire logic              data_wr,
    input  wire logic [7:0]        data_wdata,
    input  wire logic              mapped_mode,
    // Debug port (pins)
    input  wire logic              pdp_access_enable,
    input  wire logic              pdp_req,
    input  wire logic              pdp_we,
    input  wire logic [ADDR_W-1:0] pdp_addr,
    input  wire logic [7:0]        pdp_wdata,
    // Status
    output logic                   busy,
    output logic                   nonvolatile_access_enabled,
    output logic [ADDR_W-1:0]      address_byte0_reg,
    output logic [7:0]             data_byte0_reg,
    output logic [7:0]             pdp_rdata,
    output logic                   pdp_rvalid,
    output logic                   read_blocked
);
    ////////////////////////////////////////////////////////////////////////////
    ees_state_type     state_r, state_nxt;
    logic [BYTE_W-1:0] idx_r;
    logic [PAGE_W-1:0] pg_r;
    logic [7:0]        eemem_r [PAGE_BYTES*NUM_PAGES];
    logic [2:0]        ccp_cnt_r;
    logic              en_s, req_s, req_d_r;
    logic              ccp_open, exec_ok, pdp_go;
    logic              buf_load, buf_clear;
    logic [BYTE_W-1:0] buf_idx;
    logic [7:0]        buf_rd;
    logic              buf_tag, buf_any;
    logic              last_idx;
    localparam int     PIN_W = 1 + ADDR_W + 8;
    logic [CMD_W-1:0]  op_r;
    logic [PIN_W-1:0]  pins, pins_s;
    logic              we_s;
    logic [ADDR_W-1:0] addr_s;
    logic [7:0]        wdata_s;

    function automatic logic [BYTE_W-1:0] byte_of(input logic [ADDR_W-1:0] a);
        byte_of = a[BYTE_W-1:0];
    endfunction
    function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
        page_of = a[ADDR_W-1:BYTE_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ees_sync u_sync_en (.clk(clk), .rstn(rstn), .d(pdp_access_enable), .q(en_s));
    ees_sync u_sync_rq (.clk(clk), .rstn(rstn), .d(pdp_req), .q(req_s));

    // Data pins pass two flops too; they settle before the synchronised request edge
    assign pins = {pdp_we, pdp_addr, pdp_wdata};
    genvar gp;
    generate
        for (gp = 0; gp < PIN_W; gp++) begin : g_pin_sync
            ees_sync u_sync_pin (.clk(clk), .rstn(rstn), .d(pins[gp]), .q(pins_s[gp]));
        end
    endgenerate
    assign {we_s, addr_s, wdata_s} = pins_s;

    always_ff @(posedge clk) begin
        if (!rstn) req_d_r <= 1'b0;
        else       req_d_r <= req_s;
    end

    // Debug port shares the controller with software once enabled
    assign nonvolatile_access_enabled = en_s;
    assign pdp_go = en_s && req_s && !req_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Protection window opened by the unlock strobe
    always_ff @(posedge clk) begin
        if (!rstn)                         ccp_cnt_r <= 3'h0;
        else if (config_change_protection) ccp_cnt_r <= CCP_WINDOW;
        else if (ccp_cnt_r != 3'h0)        ccp_cnt_r <= ccp_cnt_r - 3'h1;
    end
    assign ccp_open = (ccp_cnt_r != 3'h0);
    // Debug port needs no protection sequence
    assign exec_ok = execute_command_bit && (ccp_open || en_s) && state_r == ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Address and data registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            address_byte0_reg <= ADDR_RST;
        end else if (pdp_go) begin
            address_byte0_reg <= addr_s;
        end else if (addr_wr) begin
            address_byte0_reg <= addr_wdata;
        end
    end

    // Load strobes: software data write or debug write, both with load command
    assign buf_load = state_r == ST_IDLE && cmd_field == CMD_LOAD_BUF && !mapped_mode &&
                      ((data_wr && ccp_open) || (pdp_go && we_s));
    assign buf_clear = state_r == ST_CLRBUF || state_r == ST_POST;
    assign buf_idx = (state_r == ST_IDLE) ? byte_of(pdp_go ? addr_s : address_byte0_reg) : idx_r;

    ees_page_buf u_buf (
        .clk       (clk),
        .rstn      (rstn),
        .load      (buf_load),
        .load_idx  (buf_idx),
        .load_data (pdp_go ? wdata_s : data_wdata),
        .clear     (buf_clear),
        .rd_idx    (buf_idx),
        .rd_data   (buf_rd),
        .rd_tag    (buf_tag),
        .any_tag   (buf_any)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign last_idx = (idx_r == BYTE_W'(PAGE_BYTES - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (exec_ok) begin
                    case (cmd_field)
                        CMD_ERASE_BUF:  state_nxt = ST_CLRBUF;
                        CMD_ERASE_PAGE: state_nxt = ST_ERASE;
                        CMD_WRITE_PAGE: state_nxt = ST_WRITE;
                        CMD_ERWR_PAGE:  state_nxt = ST_ERASE;
                        CMD_ERASE_ALL:  state_nxt = ST_ERALL;
                        default:        state_nxt = ST_IDLE;
                    endcase
                end
            end
            ST_CLRBUF: state_nxt = ST_IDLE;
            ST_ERASE: begin
                if (last_idx) state_nxt = (op_r == CMD_ERWR_PAGE) ? ST_WRITE : ST_IDLE;
            end
            ST_WRITE: begin
                if (last_idx) state_nxt = ST_POST;
            end
            ST_ERALL: begin
                if (last_idx && pg_r == PAGE_W'(NUM_PAGES - 1)) state_nxt = ST_IDLE;
            end
            ST_POST: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) state_r <= ST_IDLE;
        else       state_r <= state_nxt;
    end

    // Command latched at the trigger so a later change of the field cannot split an operation
    always_ff @(posedge clk) begin
        if (!rstn)        op_r <= CMD_NOP;
        else if (exec_ok) op_r <= cmd_field;
    end

    // Byte and page walk counters
    always_ff @(posedge clk) begin
        if (!rstn) begin
            idx_r <= '0;
            pg_r  <= '0;
        end else if (state_r == ST_IDLE) begin
            idx_r <= '0;
            pg_r  <= (cmd_field == CMD_ERASE_ALL) ? '0 : page_of(address_byte0_reg);
        end else if (state_r == ST_ERASE || state_r == ST_WRITE || state_r == ST_ERALL) begin
            idx_r <= idx_r + 1'b1;
            if (state_r == ST_ERALL && last_idx) pg_r <= pg_r + 1'b1;
        end
    end

    // Array update: only tagged locations are touched
    always_ff @(posedge clk) begin
        if ((state_r == ST_ERASE || state_r == ST_ERALL) && buf_tag) begin
            eemem_r[{pg_r, idx_r}] <= ERASED_BYTE;
        end else if (state_r == ST_WRITE && buf_tag) begin
            eemem_r[{pg_r, idx_r}] <= buf_rd;
        end
    end

    // Status flags follow the next state, so they change on the same edge as the sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy         <= 1'b0;
            read_blocked <= 1'b0;
        end else begin
            busy         <= (state_nxt != ST_IDLE);
            read_blocked <= (state_nxt == ST_ERASE || state_nxt == ST_WRITE || state_nxt == ST_ERALL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte reads
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_byte0_reg <= DATA_RST;
        end else if (exec_ok && cmd_field == CMD_READ && !mapped_mode) begin
            data_byte0_reg <= eemem_r[address_byte0_reg];
        end else if (data_wr && state_r == ST_IDLE) begin
            data_byte0_reg <= data_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pdp_rdata  <= DATA_RST;
            pdp_rvalid <= 1'b0;
        end else begin
            pdp_rvalid <= 1'b0;
            if (pdp_go && !we_s && cmd_field == CMD_READ && !read_blocked && !busy) begin
                pdp_rdata  <= eemem_r[addr_s];
                pdp_rvalid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_busy_start;
        @(posedge clk) disable iff (!rstn)
        (exec_ok && cmd_field == CMD_ERASE_BUF) |=> busy ##1 !busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("buffer clear busy wrong");

    property p_no_ccp;
        @(posedge clk) disable iff (!rstn)
        (execute_command_bit && !ccp_open && !en_s && !busy) |=> !busy;
    endproperty
    a_no_ccp: assert property (p_no_ccp) else $error("unprotected trigger accepted");

    property p_page_len;
        @(posedge clk) disable iff (!rstn)
        (exec_ok && cmd_field == CMD_WRITE_PAGE) |=> busy [*8];
    endproperty
    a_page_len: assert property (p_page_len) else $error("page write ended early");

    property p_erwr;
        @(posedge clk) disable iff (!rstn)
        (state_r == ST_ERASE && last_idx && op_r == CMD_ERWR_PAGE) |=> state_r == ST_WRITE;
    endproperty
    a_erwr: assert property (p_erwr) else $error("erase-write not atomic");

    property p_post_clear;
        @(posedge clk) disable iff (!rstn)
        (state_r == ST_WRITE && last_idx) |=> ##1 !buf_any;
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("buffer not cleared after write");

    property p_blocked;
        @(posedge clk) disable iff (!rstn)
        read_blocked |=> !pdp_rvalid;
    endproperty
    a_blocked: assert property (p_blocked) else $error("read served while busy");

    property p_map;
        @(posedge clk) disable iff (!rstn)
        (mapped_mode && !en_s && data_wr) |=> $stable(buf_any) || !buf_any;
    endproperty
    a_map: assert property (p_map) else $error("mapped mode loaded buffer");

    property p_enable;
        @(posedge clk) disable iff (!rstn)
        !nonvolatile_access_enabled |=> !pdp_rvalid;
    endproperty
    a_enable: assert property (p_enable) else $error("debug read served while disabled");

    property p_load;
        @(posedge clk) disable iff (!rstn)
        buf_load |=> buf_any;
    endproperty
    a_load: assert property (p_load) else $error("load did not tag");

    c_erall:  cover property (@(posedge clk) disable iff (!rstn) state_r == ST_ERALL ##1 state_r == ST_IDLE);
    c_erwr:   cover property (@(posedge clk) disable iff (!rstn) state_r == ST_ERASE ##1 state_r == ST_WRITE);
    c_pdp_rd: cover property (@(posedge clk) disable iff (!rstn) pdp_rvalid);
endmodule

// >>> ees_pkg.sv
// Package with constants and types for the EEPROM command sequencer
package ees_pkg;
    localparam int ADDR_W       = 12;
    localparam int BYTE_W       = 5;
    localparam int PAGE_W       = ADDR_W - BYTE_W;
    localparam int PAGE_BYTES   = 32;
    localparam int NUM_PAGES    = 128;
    localparam int CMD_W        = 7;

    localparam logic [6:0] CMD_NOP        = 7'h00;
    localparam logic [6:0] CMD_READ       = 7'h06;
    localparam logic [6:0] CMD_ERASE_ALL  = 7'h30;
    localparam logic [6:0] CMD_ERASE_PAGE = 7'h32;
    localparam logic [6:0] CMD_LOAD_BUF   = 7'h33;
    localparam logic [6:0] CMD_WRITE_PAGE = 7'h34;
    localparam logic [6:0] CMD_ERWR_PAGE  = 7'h35;
    localparam logic [6:0] CMD_ERASE_BUF  = 7'h36;

    // Protection window after the unlock strobe, in cycles
    localparam logic [2:0] CCP_WINDOW     = 3'h4;
    localparam logic [7:0] ERASED_BYTE    = 8'hff;
    localparam logic [7:0] DATA_RST       = 8'h00;
    localparam logic [11:0] ADDR_RST      = 12'h000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CLRBUF = 3'b001,
        ST_ERASE  = 3'b010,
        ST_WRITE  = 3'b011,
        ST_ERALL  = 3'b100,
        ST_POST   = 3'b101
    } ees_state_type;
endpackage

// >>> ees_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module ees_sync
    import ees_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// >>> ees_page_buf.sv
// Tagged EEPROM page buffer with clear
`timescale 1ns/1ns
module ees_page_buf
    import ees_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Load and clear
    input  wire logic              load,
    input  wire logic [BYTE_W-1:0] load_idx,
    input  wire logic [7:0]        load_data,
    input  wire logic              clear,
    // Lookup
    input  wire logic [BYTE_W-1:0] rd_idx,
    output logic [7:0]             rd_data,
    output logic                   rd_tag,
    output logic                   any_tag
);
    logic [7:0]            mem_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] tag_r;

    always_ff @(posedge clk) begin
        if (!rstn || clear) begin
            tag_r <= '0;
        end else if (load) begin
            tag_r[load_idx] <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PAGE_BYTES; g++) begin : g_byte
            always_ff @(posedge clk) begin
                if (!rstn || clear) begin
                    mem_r[g] <= ERASED_BYTE;
                end else if (load && load_idx == BYTE_W'(g)) begin
                    mem_r[g] <= load_data;
                end
            end
        end
    endgenerate

    assign rd_data = mem_r[rd_idx];
    assign rd_tag  = tag_r[rd_idx];
    assign any_tag = |tag_r;
endmodule

// >>> ees_prog_model.sv
// Debug-port programmer model driving the pin side of the sequencer
`timescale 1ns/1ns
module ees_prog_model
    import ees_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Debug pins
    output logic                   pdp_access_enable,
    output logic                   pdp_req,
    output logic                   pdp_we,
    output logic [ADDR_W-1:0]      pdp_addr,
    output logic [7:0]             pdp_wdata,
    input  wire logic [7:0]        pdp_rdata,
    input  wire logic              pdp_rvalid
);
    initial begin
        {pdp_access_enable, pdp_req, pdp_we, pdp_addr, pdp_wdata} = '0;
    end

    task automatic enable;
        @(negedge clk);
        pdp_access_enable = 1'b1;
    endtask

    // One byte per access at its full mapped address
    task automatic access(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                          output logic [7:0] rd, output logic ok);
        ok = 1'b0;
        rd = 'x;
        pdp_we = we;
        pdp_addr = a;
        pdp_wdata = d;
        repeat (4) @(negedge clk);
        pdp_req = 1'b1;
        repeat (12) begin
            @(negedge clk);
            if (pdp_rvalid === 1'b1) begin
                ok = 1'b1;
                rd = pdp_rdata;
            end
        end
        pdp_req = 1'b0;
        repeat (6) @(negedge clk);
        // Released lines show the inverse so stale values never match
        pdp_we = ~we;
        pdp_addr = ~a;
        pdp_wdata = ~d;
    endtask
endmodule

// >>> tb.sv
// Self-checking bench for the EEPROM command sequencer
`timescale 1ns/1ns
module tb
    import ees_pkg::*;
;
    logic              clk;
    logic              rstn;
    logic [CMD_W-1:0]  cmd_field;
    logic              execute_command_bit;
    logic              config_change_protection;
    logic              addr_wr;
    logic [ADDR_W-1:0] addr_wdata;
    logic              data_wr;
    logic [7:0]        data_wdata;
    logic              mapped_mode;
    logic              pdp_access_enable, pdp_req, pdp_we;
    logic [ADDR_W-1:0] pdp_addr, address_byte0_reg, a;
    logic [7:0]        pdp_wdata, pdp_rdata, data_byte0_reg, d;
    logic              busy, nonvolatile_access_enabled, pdp_rvalid, read_blocked, ok, dbg_on;
    logic [7:0]        mem [0:4095];
    logic [7:0]        buf_d [0:31];
    logic              buf_t [0:31];
    logic [PAGE_W-1:0] pg;
    logic [4:0]        ix [0:5];
    int                num_errors;
    int                comparisons;
    int                n;
    integer            seed;

    ees_cmd_seq dut (.clk, .rstn, .cmd_field, .execute_command_bit, .config_change_protection, .addr_wr,
                     .addr_wdata, .data_wr, .data_wdata, .mapped_mode, .pdp_access_enable, .pdp_req,
                     .pdp_we, .pdp_addr, .pdp_wdata, .busy, .nonvolatile_access_enabled,
                     .address_byte0_reg, .data_byte0_reg, .pdp_rdata, .pdp_rvalid, .read_blocked);
    ees_prog_model prog (.clk, .pdp_access_enable, .pdp_req, .pdp_we, .pdp_addr, .pdp_wdata,
                         .pdp_rdata, .pdp_rvalid);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(negedge clk);
    endtask
    task automatic chk_val(input string s, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_bit(input string s, input logic e, input logic g);
        chk_val(s, {15'h0, e}, {15'h0, g});
    endtask
    task automatic complete_run;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic int busy_len(input logic [6:0] c);
        case (c)
            CMD_ERASE_BUF:  return 1;
            CMD_ERASE_PAGE: return PAGE_BYTES;
            CMD_WRITE_PAGE: return PAGE_BYTES + 1;
            CMD_ERWR_PAGE:  return 2 * PAGE_BYTES + 1;
            CMD_ERASE_ALL:  return PAGE_BYTES * NUM_PAGES;
            default:        return 0;
        endcase
    endfunction
    task automatic set_addr(input logic [ADDR_W-1:0] x);
        addr_wdata = x;
        addr_wr = 1'b1;
        tick;
        addr_wr = 1'b0;
        chk_val("address_byte0_reg", {4'h0, x}, {4'h0, address_byte0_reg});
    endtask
    task automatic load(input logic [ADDR_W-1:0] x, input logic [7:0] v);
        cmd_field = CMD_LOAD_BUF;
        set_addr(x);
        config_change_protection = 1'b1;
        data_wdata = v;
        tick;
        config_change_protection = 1'b0;
        data_wr = 1'b1;
        tick;
        data_wr = 1'b0;
        if (!mapped_mode) begin
            buf_d[x[4:0]] = v;
            buf_t[x[4:0]] = 1'b1;
        end
    endtask
    task automatic exec(input logic [6:0] c, input logic unl, input logic [ADDR_W-1:0] x);
        int k;
        int e;
        logic [PAGE_W-1:0] p;
        k = 0;
        p = x[ADDR_W-1:BYTE_W];
        e = (unl || dbg_on) ? busy_len(c) : 0;
        set_addr(x);
        cmd_field = c;
        config_change_protection = unl;
        tick;
        config_change_protection = 1'b0;
        execute_command_bit = 1'b1;
        tick;
        execute_command_bit = 1'b0;
        while (busy === 1'b1 && k < 5000) begin
            if (k == 0) chk_bit("read_blocked", c != CMD_ERASE_BUF, read_blocked);
            k++;
            tick;
        end
        chk_val("busy cycles", 16'(e), 16'(k));
        if (e == 0) return;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (buf_t[i]) begin
                case (c)
                    CMD_ERASE_PAGE: mem[{p, 5'(i)}] = ERASED_BYTE;
                    CMD_WRITE_PAGE: mem[{p, 5'(i)}] = buf_d[i];
                    CMD_ERWR_PAGE:  mem[{p, 5'(i)}] = buf_d[i];
                    CMD_ERASE_ALL:  for (int q = 0; q < NUM_PAGES; q++) mem[{7'(q), 5'(i)}] = ERASED_BYTE;
                    default: ;
                endcase
            end else if (c == CMD_ERWR_PAGE) begin
                mem[{p, 5'(i)}] = 'x;
            end
            if (c inside {CMD_ERASE_BUF, CMD_WRITE_PAGE, CMD_ERWR_PAGE}) buf_t[i] = 1'b0;
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] x);
        exec(CMD_READ, 1'b1, x);
        if (^mem[x] !== 1'bx) chk_val("data_byte0_reg", {8'h0, mem[x]}, {8'h0, data_byte0_reg});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        complete_run;
    end

    initial begin
        seed = 32'h3ccd;
        num_errors = 0;
        comparisons = 0;
        rstn = 1'b0;
        {cmd_field, execute_command_bit, config_change_protection, addr_wr, data_wr, mapped_mode} = '0;
        addr_wdata = ADDR_RST;
        data_wdata = DATA_RST;
        dbg_on = 1'b0;
        foreach (mem[i]) mem[i] = 'x;
        foreach (buf_t[i]) buf_t[i] = 1'b0;
        repeat (6) tick;
        rstn = 1'b1;
        chk_bit("busy", 1'b0, busy);
        chk_bit("nonvolatile_access_enabled", 1'b0, nonvolatile_access_enabled);
        chk_val("address_byte0_reg", {4'h0, ADDR_RST}, {4'h0, address_byte0_reg});
        exec(CMD_ERASE_BUF, 1'b0, 12'h000);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            load({7'($random(seed)), 5'(i)}, 8'($random(seed)));
        end
        exec(CMD_ERASE_ALL, 1'b1, 12'h000);
        exec(CMD_ERASE_BUF, 1'b1, 12'h000);
        repeat (6) rd(12'($random(seed)));
        for (int r = 0; r < 2; r++) begin
            pg = {r[0], 6'($random(seed))};
            foreach (ix[j]) ix[j] = 5'($random(seed));
            for (int k = 0; k < 3; k++) begin
                foreach (ix[j]) load({pg, ix[j]}, 8'($random(seed)));
                exec(k == 0 ? CMD_WRITE_PAGE : k == 1 ? CMD_ERASE_PAGE : CMD_ERWR_PAGE, 1'b1, {pg, 5'h1f});
                foreach (ix[j]) rd({pg, ix[j]});
                exec(CMD_ERASE_BUF, 1'b1, 12'h000);
            end
        end
        mapped_mode = 1'b1;
        load(12'h040, 8'h5a);
        exec(CMD_READ, 1'b1, 12'h040);
        chk_val("data_byte0_reg", 16'h005a, {8'h0, data_byte0_reg});
        mapped_mode = 1'b0;
        exec(CMD_WRITE_PAGE, 1'b1, 12'h040);
        rd(12'h040);
        prog.enable();
        n = 0;
        while (nonvolatile_access_enabled !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        chk_bit("nonvolatile_access_enabled", 1'b1, nonvolatile_access_enabled);
        dbg_on = 1'b1;
        a = 12'($random(seed));
        cmd_field = CMD_READ;
        prog.access(1'b0, a, 8'h00, d, ok);
        chk_bit("pdp_rvalid", 1'b1, ok);
        if (^mem[a] !== 1'bx) chk_val("pdp_rdata", {8'h0, mem[a]}, {8'h0, d});
        cmd_field = CMD_LOAD_BUF;
        prog.access(1'b1, {pg, 5'h07}, 8'hc3, d, ok);
        chk_val("address_byte0_reg", {4'h0, pg, 5'h07}, {4'h0, address_byte0_reg});
        buf_d[7] = 8'hc3;
        buf_t[7] = 1'b1;
        exec(CMD_ERWR_PAGE, 1'b0, {pg, 5'h00});
        rd({pg, 5'h07});
        fork
            exec(CMD_ERASE_ALL, 1'b0, 12'h000);
            begin
                repeat (8) tick;
                cmd_field = CMD_READ;
                prog.access(1'b0, 12'h000, 8'h00, d, ok);
                chk_bit("pdp_rvalid", 1'b0, ok);
            end
        join
        complete_run;
    end
endmodule
